/* gdwd_checker.sv */
// Purpose: Port level assertions for the gate driver watchdog unit.
// Assumes: Sees only the top module ports, one clock domain.
// Notes: The config register is shadowed from bus writes to qualify reactions.
`timescale 1ns/1ps
module gdwd_checker (
    input wire logic clock_i, // Clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire gdwd_pkg::gdwd_bus_t bus_i, // Register request.
    input wire logic [31:0] rdata_o, // Read data.
    input wire gdwd_pkg::gdwd_rails_t rails_i, // Rail flags.
    input wire logic rlock_fault_i, // Locked rotor level.
    input wire logic fault_out_low_o, // Fault pin.
    input wire gdwd_pkg::gdwd_brake_t brake_o, // Brake request.
    input wire logic stop_o, // Stop state.
    input wire logic irq_o // Interrupt.
);
    import gdwd_pkg::*;
    logic [31:0] cfg_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RST;
        end else if (bus_i.wr && bus_i.addr == ADDR_CFG) begin
            cfg_q <= bus_i.wdata;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence st_read;
        bus_i.rd && bus_i.addr == ADDR_FAULT_STATUS_REG;
    endsequence
    sequence mask_off;
        bus_i.wr && bus_i.addr == ADDR_IRQ_MASK && bus_i.wdata == 32'h0;
    endsequence
    chk_unmapped_zero: assert property (
        bus_i.rd && bus_i.addr > ADDR_CTRL |=> rdata_o == 32'h0) else $error("Unmapped read.");
    chk_rdata_holds: assert property (
        !bus_i.rd |=> $stable(rdata_o)) else $error("Read data moved without a read.");
    chk_stop_sticky: assert property (
        stop_o |=> stop_o) else $error("Stop left without reset.");
    chk_stop_status: assert property (
        st_read ##0 stop_o |=> rdata_o[FST_STOP]) else $error("Stop bit not reported.");
    chk_buck_cause: assert property (
        $rose(stop_o) |-> !$past(rails_i.buck_uv_ok, 2)) else $error("Stop with buck rail up.");
    chk_irq_masked: assert property (
        mask_off |-> ##2 !irq_o) else $error("Interrupt high with mask clear.");
    chk_pin_report: assert property (
        $fell(fault_out_low_o) && rails_i.buck_uv_ok && !rlock_fault_i |-> cfg_q[CFG_REPORT_LO])
        else $error("Fault pin driven without pin report.");
    chk_brake_gate: assert property (
        $rose(brake_o.active) |-> cfg_q[CFG_BRAKE] && cfg_q[CFG_REPORT_LO+:2] == 2'b10
        && cfg_q[CFG_INSEL_LO+:2] inside {2'b00, 2'b11}) else $error("Brake not allowed.");
    chk_brake_low: assert property (
        brake_o.active && cfg_q[CFG_BRKCFG_LO+:2] == 2'b01 |-> brake_o.ls_on && !brake_o.hs_on)
        else $error("Low side brake wrong.");
endmodule : gdwd_checker

bind gdwd_top gdwd_checker i_chk (.clock_i, .rst_n_i, .bus_i, .rdata_o, .rails_i,
    .rlock_fault_i, .fault_out_low_o, .brake_o, .stop_o, .irq_o);

/* gdwd_host_model.sv */
// Purpose: Host side source of the watchdog clock on the driver enable pin.
// Assumes: Clock runs only while run_i is high; pin is low otherwise.
// Notes: A stopped clock is how the host shows a software hang.
`timescale 1ns/1ps
module gdwd_host_model #(
    parameter int HALF_CYC = 125000 // Half period in system cycles.
) (
    input wire logic clock_i, // System clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic run_i, // Produce the clock.
    output logic pin_o // Decoded enable pin level.
);
    int cnt_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_q <= 0;
            pin_o <= 1'b0;
        end else if (cnt_q == HALF_CYC - 1) begin
            cnt_q <= 0;
            pin_o <= !pin_o;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : gdwd_host_model

/* gdwd_pkg.sv */
// Purpose: Shared constants and types for the gate driver watchdog unit.
// Assumes: One 125 MHz clock; registers on a plain strobe port.
// Notes: Register offsets and field positions are held here only.
package gdwd_pkg;

    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned WDCLK_HZ = 500;
    localparam int unsigned WDCLK_CYC = CLK_HZ / WDCLK_HZ;
    localparam int unsigned WDCLK_TOL_PCT = 10;
    localparam logic [31:0] WDCLK_MIN_CYC = 32'(WDCLK_CYC - (WDCLK_CYC * WDCLK_TOL_PCT) / 100);
    localparam logic [31:0] WDCLK_MAX_CYC = 32'(WDCLK_CYC + (WDCLK_CYC * WDCLK_TOL_PCT) / 100);
    localparam int unsigned TICK_US = 100;
    localparam logic [15:0] TICK_CYC = 16'((CLK_HZ / 1000000) * TICK_US);

    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_CFG2 = 4'h1;
    localparam logic [3:0] ADDR_FAULT_STATUS_REG = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h5;

    // watchdog_config_reg fields.
    localparam int CFG_EN = 0;
    localparam int CFG_INSEL_LO = 1;
    localparam int CFG_REPORT_LO = 3;
    localparam int CFG_LATCH = 5;
    localparam int CFG_BRAKE = 6;
    localparam int CFG_BRKCFG_LO = 7;
    localparam int CFG_PERIOD_LO = 16;
    // watchdog_config_reg_second fields.
    localparam int CFG2_BK_DIS = 0;
    localparam int CFG2_ATT_LO = 1;
    localparam int CFG2_DLY_LO = 4;
    localparam int CFG2_BKPER_LO = 16;
    // fault_status_reg fields and the ctrl clear bit.
    localparam int FST_GEN = 0;
    localparam int FST_BUCK = 1;
    localparam int FST_REG = 2;
    localparam int FST_STOP = 3;
    localparam int CTRL_CLR = 0;

    localparam logic [31:0] CFG_RST = 32'h0064_0000;
    localparam logic [31:0] CFG2_RST = 32'h0064_0036;

    typedef enum logic [1:0] {
        GDWD_SEL_ENPIN = 2'b00,
        GDWD_SEL_REG = 2'b01,
        GDWD_SEL_CP = 2'b10,
        GDWD_SEL_READ = 2'b11
    } gdwd_sel_t;

    typedef enum logic [1:0] {
        GDWD_REP_STATUS = 2'b00,
        GDWD_REP_PIN = 2'b01,
        GDWD_REP_BRAKE = 2'b10,
        GDWD_REP_RSVD = 2'b11
    } gdwd_rep_t;

    typedef enum logic [1:0] {
        GDWD_BRK_HS = 2'b00,
        GDWD_BRK_LS = 2'b01,
        GDWD_BRK_ALT = 2'b10,
        GDWD_BRK_HIZ = 2'b11
    } gdwd_brk_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gdwd_bus_t;

    typedef struct packed {
        logic buck_uv_ok;
        logic reg_uv_ok;
        logic hs_uv_ok;
        logic ls_uv_ok;
    } gdwd_rails_t;

    typedef struct packed {
        logic active;
        logic hs_on;
        logic ls_on;
        logic hiz;
    } gdwd_brake_t;

endpackage : gdwd_pkg

/* gdwd_top.sv */
// Purpose: Buck start-up, general purpose and locked rotor watchdogs of a gate driver.
// Assumes: Inputs synchronous to clock_i; rails flags high once a rail has reached level.
// Notes: Watchdog and restart delay counters tick on a 100 us enable; locked rotor detection only reports.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module gdwd_top (
    input wire logic clock_i, // System clock, 125 MHz.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire gdwd_pkg::gdwd_bus_t bus_i, // Register port request.
    output logic [31:0] rdata_o, // Read data, one cycle after the read strobe.
    input wire logic driver_enable_pin_i, // Decoded watchdog clock on the enable pin.
    input wire gdwd_pkg::gdwd_rails_t rails_i, // Rail undervoltage release flags.
    input wire logic rlock_fault_i, // Locked rotor detection from the hall logic.
    output logic fault_out_low_o, // Fault pin, active low.
    output gdwd_pkg::gdwd_brake_t brake_o, // Brake request to the gate stage.
    output logic regulator_enable_o, // Digital regulator start enable.
    output logic stop_o, // Device stop until power cycle.
    output logic irq_o // Level interrupt.
);
    import gdwd_pkg::*;

    logic [31:0] cfg_q, cfg2_q;
    logic [3:0] fst_q, irq_st_q, irq_mask_q;
    logic [31:0] rdata_q;
    logic [15:0] tick_cnt_q;
    logic tick;
    logic clr_wr, fst_rd;
    gdwd_sel_t sel;
    gdwd_rep_t rep;
    gdwd_brk_t brk;
    logic [15:0] gen_period, buck_period;
    logic [2:0] att_cfg;
    logic [11:0] dly_cfg;

    assign sel = gdwd_sel_t'(cfg_q[CFG_INSEL_LO +: 2]);
    assign rep = gdwd_rep_t'(cfg_q[CFG_REPORT_LO +: 2]);
    assign brk = gdwd_brk_t'(cfg_q[CFG_BRKCFG_LO +: 2]);
    assign gen_period = cfg_q[CFG_PERIOD_LO +: 16];
    assign buck_period = cfg2_q[CFG2_BKPER_LO +: 16];
    assign att_cfg = cfg2_q[CFG2_ATT_LO +: 3];
    assign dly_cfg = cfg2_q[CFG2_DLY_LO +: 12];
    assign clr_wr = bus_i.wr && bus_i.addr == ADDR_CTRL && bus_i.wdata[CTRL_CLR];
    assign fst_rd = bus_i.rd && bus_i.addr == ADDR_FAULT_STATUS_REG;

    // Register writes; the two config registers and the interrupt mask are stored here.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RST;
            cfg2_q <= CFG2_RST;
            irq_mask_q <= 4'h0;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADDR_CFG) cfg_q <= bus_i.wdata;
            if (bus_i.addr == ADDR_CFG2) cfg2_q <= bus_i.wdata;
            if (bus_i.addr == ADDR_IRQ_MASK) irq_mask_q <= bus_i.wdata[3:0];
        end
    end

    // Slow tick keeps the counters narrow; timeouts resolve to 100 us.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) tick_cnt_q <= 16'h0000;
        else if (tick) tick_cnt_q <= 16'h0000;
        else tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
    assign tick = tick_cnt_q == TICK_CYC - 16'h0001;

    // Buck start-up watchdog.
    logic [15:0] buck_cnt_q;
    logic buck_done_q, buck_to;
    assign buck_to = !cfg2_q[CFG2_BK_DIS] && !buck_done_q && buck_cnt_q >= buck_period;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buck_cnt_q <= 16'h0000;
            buck_done_q <= 1'b0;
        end else if (rails_i.buck_uv_ok) begin
            buck_done_q <= 1'b1;
            buck_cnt_q <= 16'h0000;
        end else if (!buck_done_q && !cfg2_q[CFG2_BK_DIS] && tick && !buck_to) begin
            buck_cnt_q <= buck_cnt_q + 16'h0001;
        end
    end

    // Stop is only undone by reset, which stands for a power cycle.
    logic stop_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) stop_q <= 1'b0;
        else if (buck_to) stop_q <= 1'b1;
    end

    // Enable-pin clock checker: every rising edge closes one period.
    logic pin_q, pin_good, pin_kick, pin_bad;
    logic [31:0] per_cnt_q, high_cnt_q;
    assign pin_kick = driver_enable_pin_i && !pin_q;
    assign pin_good = per_cnt_q >= WDCLK_MIN_CYC && per_cnt_q <= WDCLK_MAX_CYC
        && high_cnt_q >= (per_cnt_q >> 2) && high_cnt_q <= per_cnt_q - (per_cnt_q >> 2);
    assign pin_bad = per_cnt_q > WDCLK_MAX_CYC;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= 1'b0;
            per_cnt_q <= 32'h0000_0000;
            high_cnt_q <= 32'h0000_0000;
        end else begin
            pin_q <= driver_enable_pin_i;
            if (pin_kick) begin
                per_cnt_q <= 32'h0000_0001;
                high_cnt_q <= 32'h0000_0001;
            end else begin
                if (!pin_bad) per_cnt_q <= per_cnt_q + 32'h0000_0001;
                if (driver_enable_pin_i && !pin_bad) high_cnt_q <= high_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Kick source of the general watchdog.
    logic gen_kick, src_ok;
    logic reg_ok_q, cp_ok_q;
    always_comb begin
        gen_kick = 1'b0;
        src_ok = 1'b0;
        unique case (sel)
            GDWD_SEL_ENPIN: begin
                gen_kick = pin_kick && pin_good;
                src_ok = !pin_bad;
            end
            GDWD_SEL_REG: begin
                gen_kick = rails_i.reg_uv_ok && !reg_ok_q;
                src_ok = rails_i.reg_uv_ok;
            end
            GDWD_SEL_CP: begin
                gen_kick = rails_i.hs_uv_ok && rails_i.ls_uv_ok && !cp_ok_q;
                src_ok = rails_i.hs_uv_ok && rails_i.ls_uv_ok;
            end
            GDWD_SEL_READ: begin
                gen_kick = fst_rd;
                src_ok = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_ok_q <= 1'b0;
            cp_ok_q <= 1'b0;
        end else begin
            reg_ok_q <= rails_i.reg_uv_ok;
            cp_ok_q <= rails_i.hs_uv_ok && rails_i.ls_uv_ok;
        end
    end

    // General purpose counter.
    logic [15:0] gen_cnt_q;
    logic gen_to, gen_run;
    assign gen_run = cfg_q[CFG_EN] && !stop_q;
    assign gen_to = gen_run && gen_cnt_q >= gen_period && !gen_kick;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) gen_cnt_q <= 16'h0000;
        else if (!gen_run || gen_kick) gen_cnt_q <= 16'h0000;
        else if (gen_to) gen_cnt_q <= 16'h0000;
        else if (tick) gen_cnt_q <= gen_cnt_q + 16'h0001;
    end

    // Regulator restart sequencer.
    logic [2:0] att_q;
    logic [11:0] dly_q;
    logic reg_off_q, reg_fail;
    assign reg_fail = gen_to && sel == GDWD_SEL_REG && att_q >= att_cfg;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            att_q <= 3'h0;
            dly_q <= 12'h000;
            reg_off_q <= 1'b0;
        end else if (gen_to && sel == GDWD_SEL_REG && att_q < att_cfg) begin
            att_q <= att_q + 3'h1;
            reg_off_q <= 1'b1;
            dly_q <= dly_cfg;
        end else if (reg_off_q) begin
            if (dly_q == 12'h000) reg_off_q <= 1'b0;
            else if (tick) dly_q <= dly_q - 12'h001;
        end
    end

    // Fault flags; a detection in the clear cycle wins.
    logic gen_fault_ev, fst_clear_gen;
    assign gen_fault_ev = gen_to && (sel != GDWD_SEL_REG || reg_fail);
    assign fst_clear_gen = clr_wr && (!cfg_q[CFG_LATCH] || src_ok);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) fst_q <= 4'h0;
        else begin
            if (gen_fault_ev) fst_q[FST_GEN] <= 1'b1;
            else if (fst_clear_gen) fst_q[FST_GEN] <= 1'b0;
            if (buck_to) fst_q[FST_BUCK] <= 1'b1;
            if (reg_fail) fst_q[FST_REG] <= 1'b1;
            else if (clr_wr) fst_q[FST_REG] <= 1'b0;
            // Set with stop itself, so a read in the first stopped cycle already shows it.
            fst_q[FST_STOP] <= stop_q || buck_to;
        end
    end

    // Sticky interrupt status, write one to clear.
    logic [3:0] irq_ev;
    assign irq_ev = {buck_to, reg_fail, rlock_fault_i, gen_fault_ev};
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) irq_st_q <= 4'h0;
        else begin
            for (int i = 0; i < 4; i++) begin
                if (irq_ev[i]) irq_st_q[i] <= 1'b1;
                else if (bus_i.wr && bus_i.addr == ADDR_IRQ_ST && bus_i.wdata[i])
                    irq_st_q[i] <= 1'b0;
            end
        end
    end

    // Outputs and brake.
    logic fault_low_q, irq_q, alt_q;
    gdwd_brake_t brake_q;
    logic brake_req;
    assign brake_req = fst_q[FST_GEN] && cfg_q[CFG_BRAKE] && rep == GDWD_REP_BRAKE
        && (sel == GDWD_SEL_ENPIN || sel == GDWD_SEL_READ);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_low_q <= 1'b1;
            irq_q <= 1'b0;
            alt_q <= 1'b0;
            brake_q <= '0;
        end else begin
            // A brake-only reaction leaves the fault pin alone.
            fault_low_q <= !((fst_q[FST_GEN] && (rep == GDWD_REP_PIN || rep == GDWD_REP_RSVD))
                || stop_q || rlock_fault_i);
            irq_q <= |(irq_st_q & irq_mask_q);
            if (tick) alt_q <= !alt_q;
            brake_q.active <= brake_req;
            brake_q.hs_on <= brake_req && (brk == GDWD_BRK_HS || (brk == GDWD_BRK_ALT && alt_q));
            brake_q.ls_on <= brake_req && (brk == GDWD_BRK_LS || (brk == GDWD_BRK_ALT && !alt_q));
            brake_q.hiz <= (brake_req && brk == GDWD_BRK_HIZ) || stop_q;
        end
    end

    // Read port.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_q <= 32'h0000_0000;
        else if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADDR_CFG: rdata_q <= cfg_q;
                ADDR_CFG2: rdata_q <= cfg2_q;
                ADDR_FAULT_STATUS_REG: rdata_q <= {28'h0000000, fst_q};
                ADDR_IRQ_ST: rdata_q <= {28'h0000000, irq_st_q};
                ADDR_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    assign fault_out_low_o = fault_low_q;
    assign brake_o = brake_q;
    assign regulator_enable_o = !reg_off_q && !stop_q;
    assign stop_o = stop_q;
    assign irq_o = irq_q;

endmodule : gdwd_top

/* gdwd_top_bench.sv */
// Purpose: Self checking bench for the gate driver watchdog unit.
// Assumes: Period field of 2 ticks keeps each timeout between 12500 and 25000 cycles.
// Notes: Buck rail is up from the start so the buck watchdog stays quiet until t_buck_stop drops the rail.
`timescale 1ns/1ps
module gdwd_top_bench;
    import gdwd_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic run = 1'b0;
    logic pin;
    logic rlock = 1'b0;
    gdwd_bus_t bus = '0;
    gdwd_rails_t rails = 4'hF;
    logic [31:0] rdata_o;
    logic fault_out_low_o, regulator_enable_o, stop_o, irq_o;
    gdwd_brake_t brake_o;
    int miscompares = 0;
    int checks = 0;
    always #4 clock_i = ~clock_i;
    gdwd_host_model i_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run), .pin_o(pin));
    gdwd_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
        .driver_enable_pin_i(pin), .rails_i(rails), .rlock_fault_i(rlock),
        .fault_out_low_o(fault_out_low_o), .brake_o(brake_o),
        .regulator_enable_o(regulator_enable_o), .stop_o(stop_o), .irq_o(irq_o));

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // Waits for the fault pin (which 0) or the brake (which 1); n gives the cycles taken.
    task automatic wait_hit(input int which, output int n);
        for (n = 0; n < 40000; n++) begin
            @(posedge clock_i);
            #1;
            if (which == 0 ? fault_out_low_o === 1'b0 : brake_o.active === 1'b1) break;
        end
        if (n == 40000) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_hit

    task automatic t_reset();
        logic [31:0] d;
        check("fault pin idle", {31'h0, fault_out_low_o}, 32'h1);
        check("stop idle", {31'h0, stop_o}, 32'h0);
        check("regulator on", {31'h0, regulator_enable_o}, 32'h1);
        rd(ADDR_CFG, d);
        check("cfg reset", d, CFG_RST);
        rd(ADDR_CFG2, d);
        check("cfg2 reset", d, CFG2_RST);
        rd(4'hA, d);
        check("unmapped read", d, 32'h0);
    endtask : t_reset

    task automatic t_read_kick();
        logic [31:0] d;
        int n;
        wr(ADDR_CFG, 32'h0002_000F);
        repeat (2) begin
            repeat (10000) @(posedge clock_i);
            rd(ADDR_FAULT_STATUS_REG, d);
            check("kept alive by reads", d[FST_GEN], 1'b0);
        end
        wait_hit(0, n);
        check("timeout not early", 32'(n >= 12000), 32'h1);
        check("timeout not late", 32'(n <= 2 * TICK_CYC + 2), 32'h1);
        rd(ADDR_IRQ_ST, d);
        check("fault event", d[0], 1'b1);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clock_i);
        check("irq unmasked", {31'h0, irq_o}, 32'h1);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_IRQ_ST, 32'h1);
        repeat (3) @(posedge clock_i);
        check("unlatched fault cleared", {31'h0, fault_out_low_o}, 32'h1);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
    endtask : t_read_kick

    task automatic t_brake();
        logic [31:0] d;
        int n;
        wr(ADDR_CFG, 32'h0002_00D1);
        wr(ADDR_CTRL, 32'h1);
        wait_hit(1, n);
        #1;
        check("brake low side", {30'h0, brake_o.hs_on, brake_o.ls_on}, 32'h1);
        check("brake leaves pin", {31'h0, fault_out_low_o}, 32'h1);
        rd(ADDR_FAULT_STATUS_REG, d);
        check("absent clock fault", d[FST_GEN], 1'b1);
        // CFG_LATCH is clear in this run, so any clear write would drop the pin-clock fault; none is issued after the fault.
        check("fault left standing", {31'h0, brake_o.active}, 32'h1);
    endtask : t_brake

    task automatic t_rlock();
        logic [31:0] d;
        @(posedge clock_i);
        rlock <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        check("rotor fault pin", {31'h0, fault_out_low_o}, 32'h0);
        @(posedge clock_i);
        rlock <= 1'b0;
        rd(ADDR_IRQ_ST, d);
        check("rotor event", d, 32'h0000_0002);
        wr(ADDR_IRQ_ST, 32'h0000_0002);
        rd(ADDR_IRQ_ST, d);
        check("rotor event cleared", d, 32'h0000_0000);
        check("rotor pin released", {31'h0, fault_out_low_o}, 32'h1);
    endtask : t_rlock

    // Reset stands for a power cycle; the buck rail is held down through it.
    task automatic t_buck_stop();
        logic [31:0] d;
        int n;
        @(posedge clock_i);
        rails.buck_uv_ok <= 1'b0;
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        wr(ADDR_CFG2, 32'h0002_0036);
        wait_hit(0, n);
        check("buck timeout not early", 32'(n >= TICK_CYC), 32'h1);
        check("buck timeout not late", 32'(n <= 2 * TICK_CYC + 2), 32'h1);
        check("stopped", {31'h0, stop_o}, 32'h1);
        check("regulator held off", {31'h0, regulator_enable_o}, 32'h0);
        rd(ADDR_FAULT_STATUS_REG, d);
        check("buck and stop flags", d, 32'h0000_000A);
        @(posedge clock_i);
        rails.buck_uv_ok <= 1'b1;
        repeat (3) @(posedge clock_i);
        check("stop kept with rail up", {31'h0, stop_o}, 32'h1);
    endtask : t_buck_stop

    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_rlock();
        t_read_kick();
        t_brake();
        t_buck_stop();
        give_verdict();
    end
endmodule : gdwd_top_bench
